// File: ccm_pkg.sv
// Purpose: Shared constants and types for the configuration chain control.
// Assumes: 20 MHz system clock; all pins sampled into that clock.
// Notes: Counts derived from times round up for least times.
//
// Contract
// - Take part in configuration only while chain enable input is low.
// - Drive chain enable output low once own configuration completes.
// - In active mode shift command and address out on serial command pin.
// - In active mode select memory by driving select low, release high.
// - In passive mode command and select pins become ordinary user I/O.
// - Enabled done pin signals user mode open-drain; else plain user I/O.
// - Optional user clock, when enabled, paces the initialization count.
// - Global clear low forces design registers cleared; high lets them run.
// - Global output enable low tri-states all user pins.
// - Mode select is held fixed and chooses the configuration mode.
// - Bitstream arrives serially on one dedicated data input.
// - Request low resets and tri-states; rising request starts configuration.
// - Passive mode takes external config clock; active mode drives it.
package ccm_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int AS_CLK_PERIOD_NS = 400;
    localparam int AS_HALF_CYC =
        (AS_CLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 3;

    localparam logic [1:0] MODE_PS = 2'h0;
    localparam logic [1:0] MODE_AS = 2'h1;

    localparam logic [7:0] READ_CMD = 8'h03;
    localparam logic [23:0] START_ADDR = 24'h000000;
    localparam int CMD_BITS = 32;
    localparam int CMD_CNT_W = 6;

    localparam int WORD_BITS = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int BITSTREAM_BITS = 1024;
    localparam int INIT_CYCLES = 64;
    localparam int SYNC_W = 11;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD = 3'h1,
        ST_LOAD = 3'h3,
        ST_INIT = 3'h2,
        ST_USER = 3'h6
    } ccm_state_type;

endpackage : ccm_pkg

// File: ccm_sync.sv
// Purpose: Two-flop synchroniser for a vector of unrelated pin levels.
// Assumes: Each bit is an independent level; no bus coherence.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module ccm_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_r <= '0;
            q_out <= '0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule : ccm_sync

// File: ccm_fifo.sv
// Purpose: Small flip-flop FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two, at least 2.
// Notes: Read data is the head entry; valid is a register.
`timescale 1ns/1ps
module ccm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [WIDTH-1:0] wr_data_in,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [WIDTH-1:0] rd_data_out
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
            $error("ccm_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign push = wr_valid_in && wr_ready_out;
    assign pop = rd_valid_out && rd_ready_in;
    assign rd_data_out = mem_r[rd_ptr_r];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            wr_ready_out <= 1'b1;
            rd_valid_out <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            case ({push, pop})
                2'b10: begin
                    count_r <= count_r + 1'b1;
                    wr_ready_out <= (count_r != (AW+1)'(DEPTH - 1));
                    rd_valid_out <= 1'b1;
                end
                2'b01: begin
                    count_r <= count_r - 1'b1;
                    wr_ready_out <= 1'b1;
                    rd_valid_out <= (count_r != (AW+1)'(1));
                end
                default: begin
                    count_r <= count_r;
                end
            endcase
        end
    end
endmodule : ccm_fifo

// File: ccm_config_ctrl.sv
// Purpose: Configuration loader and chain control of a programmable device.
// Assumes: Control pins arrive asynchronously and are synchronised to clk_in; user I/O values and word_ready_in are not.
// Notes: Pin outputs lag internal state by one register stage.
`timescale 1ns/1ps
module ccm_config_ctrl #(
    parameter int BITSTREAM_BITS = ccm_pkg::BITSTREAM_BITS,
    parameter int INIT_CYCLES = ccm_pkg::INIT_CYCLES,
    parameter int FIFO_DEPTH = ccm_pkg::FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic config_request_n_in,
    input wire logic chain_enable_n_in,
    input wire logic [1:0] config_mode_select_in,
    input wire logic config_clock_in,
    input wire logic config_data_in,
    input wire logic user_init_clock_in,
    input wire logic global_clear_n_in,
    input wire logic global_output_enable_in,
    input wire logic init_done_enable_in,
    input wire logic user_clock_enable_in,
    input wire logic user_cmd_value_in,
    input wire logic user_cmd_oe_n_in,
    input wire logic user_select_value_in,
    input wire logic user_select_oe_n_in,
    input wire logic user_done_value_in,
    input wire logic user_done_oe_n_in,
    input wire logic word_ready_in,
    output logic chain_enable_out_n_out,
    output logic serial_cmd_out,
    output logic serial_cmd_oe_n_out,
    output logic mem_select_n_out,
    output logic mem_select_oe_n_out,
    output logic config_clock_out,
    output logic config_clock_oe_n_out,
    output logic init_done_out,
    output logic init_done_oe_n_out,
    output logic [ccm_pkg::WORD_BITS-1:0] word_data_out,
    output logic word_valid_out,
    output logic user_mode_out,
    output logic design_clear_out,
    output logic io_tristate_out,
    output logic overflow_out
);
    localparam int BW = $clog2(BITSTREAM_BITS + 1);
    localparam int IW = $clog2(INIT_CYCLES + 1);
    localparam logic [BW-1:0] BITS_LAST = BW'(BITSTREAM_BITS - 1);
    localparam logic [IW-1:0] INIT_LAST = IW'(INIT_CYCLES - 1);
    localparam logic [ccm_pkg::DIV_W-1:0] DIV_LAST =
        ccm_pkg::DIV_W'(ccm_pkg::AS_HALF_CYC - 1);
    localparam logic [ccm_pkg::CMD_CNT_W-1:0] CMD_LAST =
        ccm_pkg::CMD_CNT_W'(ccm_pkg::CMD_BITS);

    generate
        if (BITSTREAM_BITS < ccm_pkg::WORD_BITS ||
            BITSTREAM_BITS % ccm_pkg::WORD_BITS != 0) begin : g_bad_bits
            $error("ccm_config_ctrl: bitstream must be whole words");
        end
        if (INIT_CYCLES < 1) begin : g_bad_init
            $error("ccm_config_ctrl: INIT_CYCLES must be >= 1");
        end
    endgenerate

    function automatic logic in_config(input ccm_pkg::ccm_state_type s);
        in_config = (s == ccm_pkg::ST_CMD) || (s == ccm_pkg::ST_LOAD);
    endfunction : in_config

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and edge detection
    logic [ccm_pkg::SYNC_W-1:0] sync_q;
    logic req_s, ce_n_s, config_clock_s, data_s, uclk_s, clr_n_s, goe_s;
    logic done_en_s, uclk_en_s;
    logic [1:0] msel_s;
    logic config_clock_d_r, uclk_d_r;
    logic ps_rise, usr_rise;

    ccm_sync #(.W(ccm_pkg::SYNC_W)) u_sync (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .d_in({config_request_n_in, chain_enable_n_in, config_mode_select_in,
               config_clock_in, config_data_in, user_init_clock_in,
               global_clear_n_in, global_output_enable_in,
               init_done_enable_in, user_clock_enable_in}),
        .q_out(sync_q)
    );

    assign {req_s, ce_n_s, msel_s, config_clock_s, data_s, uclk_s, clr_n_s, goe_s,
            done_en_s, uclk_en_s} = sync_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            config_clock_d_r <= 1'b0;
            uclk_d_r <= 1'b0;
        end else begin
            config_clock_d_r <= config_clock_s;
            uclk_d_r <= uclk_s;
        end
    end

    assign ps_rise = config_clock_s && !config_clock_d_r;
    assign usr_rise = uclk_s && !uclk_d_r;

    ////////////////////////////////////////////////////////////////////////
    // State machine
    ccm_pkg::ccm_state_type state_r, state_nxt;
    logic [1:0] mode_r;
    logic as_mode;
    logic [ccm_pkg::CMD_CNT_W-1:0] cmd_cnt_r;
    logic [BW-1:0] bit_cnt_r;
    logic [IW-1:0] init_cnt_r;
    logic as_rise, as_fall, bit_tick, init_tick;

    assign as_mode = (mode_r == ccm_pkg::MODE_AS);
    assign bit_tick = (state_r == ccm_pkg::ST_LOAD) &&
                      (as_mode ? as_rise : ps_rise);
    assign init_tick = uclk_en_s ? usr_rise : 1'b1;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ccm_pkg::ST_IDLE: begin
                if (req_s && !ce_n_s) begin
                    if (msel_s == ccm_pkg::MODE_AS) begin
                        state_nxt = ccm_pkg::ST_CMD;
                    end else if (msel_s == ccm_pkg::MODE_PS) begin
                        state_nxt = ccm_pkg::ST_LOAD;
                    end
                end
            end
            ccm_pkg::ST_CMD: begin
                if (as_fall && cmd_cnt_r == CMD_LAST) begin
                    state_nxt = ccm_pkg::ST_LOAD;
                end
            end
            ccm_pkg::ST_LOAD: begin
                if (bit_tick && bit_cnt_r == BITS_LAST) begin
                    state_nxt = ccm_pkg::ST_INIT;
                end
            end
            ccm_pkg::ST_INIT: begin
                if (init_tick && init_cnt_r == INIT_LAST) begin
                    state_nxt = ccm_pkg::ST_USER;
                end
            end
            ccm_pkg::ST_USER: begin
                state_nxt = ccm_pkg::ST_USER;
            end
            default: begin
                state_nxt = ccm_pkg::ST_IDLE;
            end
        endcase
        if (!req_s) begin
            state_nxt = ccm_pkg::ST_IDLE;
        end else if (ce_n_s && state_r != ccm_pkg::ST_USER) begin
            state_nxt = ccm_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r <= ccm_pkg::ST_IDLE;
            mode_r <= ccm_pkg::MODE_PS;
        end else begin
            state_r <= state_nxt;
            if (state_r == ccm_pkg::ST_IDLE) begin
                mode_r <= msel_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Active-mode clock divider; a pending word stalls the next rising edge
    logic [ccm_pkg::DIV_W-1:0] div_cnt_r;
    logic as_clk_r, div_tick, push_valid_r, fifo_ready, stall;

    assign div_tick = (div_cnt_r == DIV_LAST);
    assign stall = push_valid_r && !fifo_ready;
    assign as_rise = as_mode && in_config(state_r) && div_tick &&
                     !as_clk_r && !stall;
    assign as_fall = as_mode && in_config(state_r) && div_tick && as_clk_r;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_cnt_r <= '0;
            as_clk_r <= 1'b0;
        end else if (!in_config(state_r) || !as_mode) begin
            div_cnt_r <= '0;
            as_clk_r <= 1'b0;
        end else if (div_tick) begin
            if (!stall || as_clk_r) begin
                div_cnt_r <= '0;
                as_clk_r <= !as_clk_r;
            end
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command shifter: read command then start address, msb first
    logic [ccm_pkg::CMD_BITS-1:0] cmd_sh_r;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cmd_sh_r <= '0;
            cmd_cnt_r <= '0;
        end else if (state_r != ccm_pkg::ST_CMD) begin
            cmd_sh_r <= {ccm_pkg::READ_CMD, ccm_pkg::START_ADDR};
            cmd_cnt_r <= '0;
        end else begin
            if (as_rise) begin
                cmd_cnt_r <= cmd_cnt_r + 1'b1;
            end
            if (as_fall) begin
                cmd_sh_r <= {cmd_sh_r[ccm_pkg::CMD_BITS-2:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data deserialiser into the word FIFO
    logic [ccm_pkg::WORD_BITS-1:0] byte_sh_r, push_data_r;
    logic [2:0] byte_bit_r;
    logic overflow_r;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            byte_sh_r <= '0;
            byte_bit_r <= '0;
            bit_cnt_r <= '0;
            push_data_r <= '0;
            push_valid_r <= 1'b0;
            overflow_r <= 1'b0;
        end else begin
            if (push_valid_r && fifo_ready) begin
                push_valid_r <= 1'b0;
            end
            if (state_r == ccm_pkg::ST_IDLE) begin
                byte_bit_r <= '0;
                bit_cnt_r <= '0;
                overflow_r <= 1'b0;
            end else if (bit_tick) begin
                byte_sh_r <= {byte_sh_r[ccm_pkg::WORD_BITS-2:0], data_s};
                byte_bit_r <= byte_bit_r + 1'b1;
                bit_cnt_r <= bit_cnt_r + 1'b1;
                if (byte_bit_r == 3'h7) begin
                    push_data_r <= {byte_sh_r[ccm_pkg::WORD_BITS-2:0], data_s};
                    push_valid_r <= 1'b1;
                    // Passive clock cannot be stalled, so a still-pending word is overwritten and lost
                    if (push_valid_r && !fifo_ready) begin
                        overflow_r <= 1'b1;
                    end
                end
            end
        end
    end

    ccm_fifo #(.WIDTH(ccm_pkg::WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .wr_valid_in(push_valid_r),
        .wr_ready_out(fifo_ready),
        .wr_data_in(push_data_r),
        .rd_valid_out(word_valid_out),
        .rd_ready_in(word_ready_in),
        .rd_data_out(word_data_out)
    );

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            init_cnt_r <= '0;
        end else if (state_r != ccm_pkg::ST_INIT) begin
            init_cnt_r <= '0;
        end else if (init_tick) begin
            init_cnt_r <= init_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered
    logic in_user, io_off;

    assign in_user = (state_r == ccm_pkg::ST_USER);
    assign io_off = !in_user || !goe_s;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            chain_enable_out_n_out <= 1'b1;
            user_mode_out <= 1'b0;
            design_clear_out <= 1'b1;
            io_tristate_out <= 1'b1;
            overflow_out <= 1'b0;
        end else begin
            chain_enable_out_n_out <= !(in_user ||
                state_r == ccm_pkg::ST_INIT);
            user_mode_out <= in_user;
            design_clear_out <= !in_user || !clr_n_s;
            io_tristate_out <= io_off;
            overflow_out <= overflow_r;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            serial_cmd_out <= 1'b0;
            serial_cmd_oe_n_out <= 1'b1;
            mem_select_n_out <= 1'b1;
            mem_select_oe_n_out <= 1'b1;
            config_clock_out <= 1'b0;
            config_clock_oe_n_out <= 1'b1;
        end else if (as_mode && state_r != ccm_pkg::ST_IDLE) begin
            // Active pins stay driven after load so the memory stays idle
            serial_cmd_out <= (state_r == ccm_pkg::ST_CMD) &&
                              cmd_sh_r[ccm_pkg::CMD_BITS-1];
            serial_cmd_oe_n_out <= 1'b0;
            mem_select_n_out <= !in_config(state_r);
            mem_select_oe_n_out <= 1'b0;
            config_clock_out <= as_clk_r;
            config_clock_oe_n_out <= 1'b0;
        end else begin
            serial_cmd_out <= user_cmd_value_in;
            serial_cmd_oe_n_out <= user_cmd_oe_n_in || io_off;
            mem_select_n_out <= user_select_value_in;
            mem_select_oe_n_out <= user_select_oe_n_in || io_off;
            config_clock_out <= 1'b0;
            config_clock_oe_n_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            init_done_out <= 1'b0;
            init_done_oe_n_out <= 1'b1;
        end else if (done_en_s) begin
            init_done_out <= 1'b0;
            init_done_oe_n_out <= in_user;
        end else begin
            init_done_out <= user_done_value_in;
            init_done_oe_n_out <= user_done_oe_n_in || io_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    chain_gate_a: assert property ((state_r == ccm_pkg::ST_IDLE && ce_n_s)
        |=> state_r == ccm_pkg::ST_IDLE)
        else $error("left idle while chain enable high");
    chain_out_a: assert property (chain_enable_out_n_out !=
        $past(state_r == ccm_pkg::ST_INIT || state_r == ccm_pkg::ST_USER))
        else $error("chain enable out unexpected");
    chain_done_a: assert property (in_user |=> !chain_enable_out_n_out)
        else $error("chain enable out not low after completion");
    chain_busy_a: assert property (in_config(state_r)
        |=> chain_enable_out_n_out)
        else $error("chain enable out low during load");
    cmd_drive_a: assert property ((state_r == ccm_pkg::ST_CMD)
        |=> !serial_cmd_oe_n_out &&
            serial_cmd_out == $past(cmd_sh_r[ccm_pkg::CMD_BITS-1]))
        else $error("command pin not driving shifter bit");
    select_as_a: assert property ((as_mode && in_config(state_r))
        |=> !mem_select_n_out && !mem_select_oe_n_out)
        else $error("memory not selected during active load");
    ps_release_a: assert property ((!as_mode && in_user && goe_s)
        |=> mem_select_n_out == $past(user_select_value_in) &&
            mem_select_oe_n_out == $past(user_select_oe_n_in))
        else $error("select pin not released to user");
    done_pin_a: assert property ((done_en_s && state_r == ccm_pkg::ST_INIT)
        |=> !init_done_oe_n_out && !init_done_out)
        else $error("done pin not held low during init");
    init_pace_a: assert property ((state_r == ccm_pkg::ST_INIT && uclk_en_s
        && !usr_rise) |=> $stable(init_cnt_r))
        else $error("init count moved without user clock edge");
    clear_a: assert property (!clr_n_s |=> design_clear_out)
        else $error("global clear not applied");
    tristate_a: assert property ((!goe_s && !as_mode)
        |=> io_tristate_out && mem_select_oe_n_out)
        else $error("pins not tri-stated");
    mode_hold_a: assert property ((state_r != ccm_pkg::ST_IDLE &&
        $past(state_r) != ccm_pkg::ST_IDLE) |-> $stable(mode_r))
        else $error("mode changed during configuration");
    bit_count_a: assert property (bit_tick && bit_cnt_r != BITS_LAST
        |=> bit_cnt_r == $past(bit_cnt_r) + 1'b1)
        else $error("bit not counted on clock edge");
    req_reset_a: assert property (!req_s |=> state_r == ccm_pkg::ST_IDLE
        ##1 io_tristate_out)
        else $error("request low did not reset");
    clk_dir_a: assert property ((as_mode && in_config(state_r))
        |=> !config_clock_oe_n_out && config_clock_out == $past(as_clk_r))
        else $error("active clock not driven");

    as_done_c: cover property (as_mode && $rose(in_user));
    ps_done_c: cover property (!as_mode && $rose(in_user));
    fifo_full_c: cover property (!fifo_ready ##1 !fifo_ready);
    abort_c: cover property (state_r == ccm_pkg::ST_LOAD ##1 !req_s);
endmodule : ccm_config_ctrl

// File: ccm_src_model.sv
// Purpose: Far side: passive bit source or serial memory.
// Assumes: Words alternate 8'ha5, 8'h5a, first bit is msb.
// Notes: Released data shows the inverse of its last value.
`timescale 1ns/1ps
module ccm_src_model #(
    parameter int NB = 128
) (
    input wire logic go_in,
    input wire logic sel_n_in,
    input wire logic sclk_in,
    input wire logic cmd_in,
    output logic clk_out,
    output logic data_out,
    output logic [31:0] cmd_out
);
    int m = 0;
    initial clk_out = 1'b0;
    initial data_out = 1'b1;
    function automatic logic pat(input int k);
        logic [7:0] b;
        b = k[3] ? 8'h5a : 8'ha5;
        return b[7 - k % 8];
    endfunction : pat
    // Clock stands still between frames
    always @(posedge go_in) begin
        for (int n = 0; n < NB; n++) begin
            data_out = pat(n);
            #200 clk_out = 1'b1;
            #200 clk_out = 1'b0;
        end
        data_out = ~data_out;
    end
    always @(posedge sclk_in) begin
        if (!sel_n_in && m < 32) begin
            cmd_out <= {cmd_out[30:0], cmd_in};
        end
        if (!sel_n_in) begin
            m <= m + 1;
        end
    end
    always @(negedge sclk_in) begin
        if (!sel_n_in && m >= 32) begin
            data_out <= pat(m - 32);
        end
    end
    always @(posedge sel_n_in) begin
        m <= 0;
        data_out <= ~data_out;
    end
endmodule : ccm_src_model

// File: tb_fpga_config_chain_control.sv
// Purpose: Self-checking bench for the configuration chain control.
// Assumes: 128-bit stream, init count of 4, 400 ns link clock.
// Notes: Expected words come from the bench's own pattern.
`timescale 1ns/1ps
module tb_fpga_config_chain_control;
    logic clk_in = 1'b0, arst_n_in = 1'b0, config_request_n_in = 1'b0;
    logic chain_enable_n_in = 1'b0, config_clock_in, config_data_in;
    logic [1:0] config_mode_select_in = 2'h0;
    logic user_init_clock_in = 1'b0, global_clear_n_in = 1'b1;
    logic global_output_enable_in = 1'b1, init_done_enable_in = 1'b1;
    logic user_clock_enable_in = 1'b0, word_ready_in = 1'b0, go = 1'b0;
    logic uv = 1'b0, uo = 1'b1, chain_enable_out_n_out, serial_cmd_out;
    logic serial_cmd_oe_n_out, mem_select_n_out, mem_select_oe_n_out;
    logic config_clock_out, config_clock_oe_n_out, init_done_out;
    logic init_done_oe_n_out, word_valid_out, user_mode_out, overflow_out;
    logic design_clear_out, io_tristate_out;
    logic [ccm_pkg::WORD_BITS-1:0] word_data_out;
    logic [31:0] cmd;
    int miscompares = 0, cmp_count = 0;
    always #25 clk_in = ~clk_in;
    ccm_config_ctrl #(.BITSTREAM_BITS(128), .INIT_CYCLES(4)) DUT (.*,
        .user_cmd_value_in(uv), .user_cmd_oe_n_in(uo),
        .user_select_value_in(uv), .user_select_oe_n_in(uo),
        .user_done_value_in(uv), .user_done_oe_n_in(uo));
    ccm_src_model #(.NB(128)) SRC (.go_in(go), .sel_n_in(mem_select_n_out),
        .sclk_in(config_clock_out), .cmd_in(serial_cmd_out),
        .clk_out(config_clock_in), .data_out(config_data_in), .cmd_out(cmd));
    ////////////////////////////////////////
    task automatic stop_test;
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    // Bounded so a stuck flag ends as a mismatch, not a hang
    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 4000 && s !== 1'b1; i++) cyc(1);
        chk(32'(s), 32'h1);
    endtask : wait_hi
    task automatic restart(input logic [1:0] m);
        config_request_n_in = 1'b0;
        cyc(5);
        config_mode_select_in = m;
        cyc(5);
        config_request_n_in = 1'b1;
        cyc(5);
    endtask : restart
    task automatic drain(input int n);
        for (int w = 0; w < n; w++) begin
            wait_hi(word_valid_out);
            chk(word_data_out, w[0] ? 8'h5a : 8'ha5);
            word_ready_in = 1'b1;
            cyc(1);
            word_ready_in = 1'b0;
            cyc(1);
        end
    endtask : drain
    task automatic idle_run(input logic [1:0] m, input logic ce);
        chain_enable_n_in = ce;
        restart(m);
        go = 1'b1;
        cyc(1100);
        chk({word_valid_out, chain_enable_out_n_out}, 2'h1);
        go = 1'b0;
        chain_enable_n_in = 1'b0;
    endtask : idle_run
    task automatic t_passive;
        restart(2'h0);
        go = 1'b1;
        cyc(10);
        chk(init_done_oe_n_out, 1'b0);
        drain(16);
        go = 1'b0;
        wait_hi(user_mode_out);
        chk({chain_enable_out_n_out, init_done_oe_n_out}, 2'h1);
        chk({overflow_out, io_tristate_out, design_clear_out}, 3'h0);
        uv = 1'b1;
        uo = 1'b0;
        cyc(5);
        chk({serial_cmd_out, serial_cmd_oe_n_out, mem_select_n_out,
            mem_select_oe_n_out}, 4'ha);
        global_output_enable_in = 1'b0;
        cyc(5);
        chk(io_tristate_out, 1'b1);
        global_clear_n_in = 1'b0;
        cyc(5);
        chk(design_clear_out, 1'b1);
        {global_clear_n_in, global_output_enable_in, uo} = 3'h7;
        config_request_n_in = 1'b0;
        cyc(5);
        chk({io_tristate_out, user_mode_out, chain_enable_out_n_out},
            3'h5);
    endtask : t_passive
    task automatic t_active;
        restart(2'h1);
        cyc(12);
        chk({mem_select_n_out, mem_select_oe_n_out, config_clock_oe_n_out},
            3'h0);
        cyc(1200);
        chk(cmd, 32'h03000000);
        // Full FIFO must hold the clock low
        repeat (12) begin
            cyc(1);
            chk(config_clock_out, 1'b0);
        end
        drain(16);
        wait_hi(user_mode_out);
        chk({mem_select_n_out, mem_select_oe_n_out, chain_enable_out_n_out},
            3'h4);
    endtask : t_active
    // Done pin as user I/O, init paced by the user clock
    task automatic t_user;
        {init_done_enable_in, user_clock_enable_in, uv, uo} = 4'h6;
        restart(2'h0);
        go = 1'b1;
        drain(16);
        go = 1'b0;
        repeat (3) begin
            user_init_clock_in = 1'b1;
            cyc(4);
            user_init_clock_in = 1'b0;
            cyc(4);
        end
        chk(user_mode_out, 1'b0);
        user_init_clock_in = 1'b1;
        cyc(6);
        chk({user_mode_out, init_done_out, init_done_oe_n_out}, 3'h6);
        chk({config_clock_out, config_clock_oe_n_out}, 2'h1);
        user_init_clock_in = 1'b0;
        {init_done_enable_in, user_clock_enable_in, uv, uo} = 4'h9;
    endtask : t_user
    initial begin
        cyc(10);
        arst_n_in = 1'b1;
        idle_run(2'h0, 1'b1);
        t_passive;
        t_active;
        t_user;
        idle_run(2'h2, 1'b0);
        stop_test;
    end
    initial begin
        #1ms;
        miscompares++;
        stop_test;
    end
endmodule : tb_fpga_config_chain_control
